// file: logic/bvc_top.sv
// Second buck converter voltage control register and mode logic
`timescale 1ns/1ps
`include "bvc_cfg.svh"

module bvc_top
  import bvc_pkg::*;
#(
  parameter int BLANK_CYCLES = `BVC_BLANK_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Register port from the serial interface
  input  wire logic [`BVC_ADDR_W-1:0] reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [`BVC_DATA_W-1:0] reg_wdata,
  output logic      [`BVC_DATA_W-1:0] reg_rdata,
  // Password unlock and apply controls
  input  wire logic                   password_ok,
  input  wire logic                   voltage_apply,
  input  wire logic                   voltage_apply_on_disable,
  // Load condition from the converter
  input  wire logic                   light_load,
  // Converter controls
  output logic                        pulse_skip_active,
  output logic                        force_pwm,
  output logic      [`BVC_CODE_W-1:0] applied_code,
  output logic      [`BVC_MV_W-1:0]   vout_mv,
  output logic                        monitor_blank
);

  // ****************************************
  // Elaboration check
  // ****************************************
  // Blanking hold assertion looks eight cycles ahead
  if (BLANK_CYCLES < 8) begin : g_bad_blank
    $error("bvc_top: BLANK_CYCLES must be at least eight");
  end

  // ****************************************
  // Light-load input synchroniser
  // ****************************************
  logic light_meta_reg;
  logic light_sync_reg;

  // Two stages, only the second is read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      light_meta_reg <= 1'h0;
      light_sync_reg <= 1'h0;
    end else begin
      light_meta_reg <= light_load;
      light_sync_reg <= light_meta_reg;
    end
  end

  // ****************************************
  // Register write and read
  // ****************************************
  logic                   sel;
  logic                   wr_acc;
  logic                   pse_reg;
  logic                   pse_next;
  bvc_code_t              code_reg;
  bvc_code_t              code_next;
  logic [`BVC_DATA_W-1:0] rdata_reg;
  logic [`BVC_DATA_W-1:0] rdata_next;

  // Decode and password gate
  assign sel    = (reg_addr == `BVC_REG_ADDR);
  assign wr_acc = reg_wr && sel && password_ok;

  // Next register contents and read data
  always_comb begin
    pse_next   = pse_reg;
    code_next  = code_reg;
    rdata_next = `BVC_RDATA_RST;
    if (wr_acc) begin
      pse_next  = reg_wdata[`BVC_PSE_BIT];
      code_next = reg_wdata[`BVC_CODE_MSB:0];
    end
    if (reg_rd && sel) begin
      rdata_next = {pse_reg, `BVC_RSVD_VAL, code_reg};
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pse_reg   <= `BVC_PSE_RST;
      code_reg  <= `BVC_CODE_RST;
      rdata_reg <= `BVC_RDATA_RST;
    end else begin
      pse_reg   <= pse_next;
      code_reg  <= code_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // Converter mode
  // ****************************************
  bvc_mode_t mode_reg;
  bvc_mode_t mode_next;
  logic      skip_reg;
  logic      skip_next;
  logic      fpwm_reg;
  logic      fpwm_next;

  // Skip only when enabled and load is light
  always_comb begin
    case (mode_reg)
      BVC_MODE_PWM: begin
        if (pse_reg && light_sync_reg) begin
          mode_next = BVC_MODE_SKIP;
        end else begin
          mode_next = BVC_MODE_PWM;
        end
      end
      BVC_MODE_SKIP: begin
        if (!pse_reg || !light_sync_reg) begin
          mode_next = BVC_MODE_PWM;
        end else begin
          mode_next = BVC_MODE_SKIP;
        end
      end
      default: begin
        mode_next = BVC_MODE_PWM;
      end
    endcase
    skip_next = (mode_next == BVC_MODE_SKIP);
    fpwm_next = !pse_reg;
  end

  // Mode registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= BVC_MODE_PWM;
      skip_reg <= 1'h0;
      fpwm_reg <= 1'h0;
    end else begin
      mode_reg <= mode_next;
      skip_reg <= skip_next;
      fpwm_reg <= fpwm_next;
    end
  end

  // ****************************************
  // Applied code and voltage table
  // ****************************************
  bvc_code_t            appl_reg;
  bvc_code_t            appl_next;
  logic [`BVC_MV_W-1:0] mv_reg;
  logic [`BVC_MV_W-1:0] mv_next;
  logic [`BVC_MV_W-1:0] appl_wide;
  logic [`BVC_MV_W-1:0] knee_wide;

  assign appl_wide = {`BVC_MV_PAD, appl_reg};
  assign knee_wide = {`BVC_MV_PAD, `BVC_CODE_KNEE};

  // Staged code moves on an apply request
  always_comb begin
    appl_next = appl_reg;
    if (voltage_apply || voltage_apply_on_disable) begin
      appl_next = code_reg;
    end
    if (appl_reg <= `BVC_CODE_KNEE) begin
      mv_next = `BVC_MV_BASE + appl_wide * `BVC_MV_STEP_LO;
    end else begin
      mv_next = `BVC_MV_KNEE + (appl_wide - knee_wide) * `BVC_MV_STEP_HI;
    end
  end

  // Applied code registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      appl_reg <= `BVC_CODE_RST;
      mv_reg   <= `BVC_MV_KNEE;
    end else begin
      appl_reg <= appl_next;
      mv_reg   <= mv_next;
    end
  end

  // ****************************************
  // Monitor blanking after writes
  // ****************************************
  logic blank_busy;

  bvc_blank_timer #(
    .CYCLES (BLANK_CYCLES)
  ) bvc_blank_timer_i (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (wr_acc),
    .busy    (blank_busy)
  );

  // Outputs
  assign reg_rdata         = rdata_reg;
  assign pulse_skip_active = skip_reg;
  assign force_pwm         = fpwm_reg;
  assign applied_code      = appl_reg;
  assign vout_mv           = mv_reg;
  assign monitor_blank     = blank_busy;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_PSE_WRITE: assert property (
    wr_acc |=> pse_reg == $past(reg_wdata[`BVC_PSE_BIT]))
    else $error("pulse-skip enable not stored");

  AST_FORCE_PWM: assert property (
    !pse_reg |=> force_pwm && !pulse_skip_active)
    else $error("PWM not forced with pulse-skip off");

  AST_SKIP_CAUSE: assert property (
    pulse_skip_active |-> $past(pse_reg) && $past(light_sync_reg))
    else $error("pulse-skip without enable and light load");

  AST_CODE_WRITE: assert property (
    wr_acc |=> code_reg == $past(reg_wdata[`BVC_CODE_MSB:0]))
    else $error("voltage code not stored");

  AST_VOUT_MAP: assert property (
    ($past(appl_reg) <= `BVC_CODE_KNEE) |->
      vout_mv == `BVC_MV_BASE + {`BVC_MV_PAD, $past(appl_reg)}
                 * `BVC_MV_STEP_LO)
    else $error("low voltage table wrong");

  AST_RSVD_READ: assert property (
    reg_rd && sel |=> reg_rdata[`BVC_RSVD_BIT] == 1'h0 &&
      reg_rdata[`BVC_CODE_MSB:0] == $past(code_reg))
    else $error("read data wrong");

  AST_LOCKED: assert property (
    reg_wr && !password_ok |=> $stable(code_reg) && $stable(pse_reg))
    else $error("locked write took effect");

  AST_BLANK_HOLD: assert property (
    wr_acc |=> monitor_blank [*8])
    else $error("monitor blanking not held after write");

  CVR_WRITE: cover property (wr_acc);
  CVR_SKIP: cover property (!pulse_skip_active ##1 pulse_skip_active);
  CVR_LOCKED: cover property (reg_wr && sel && !password_ok);
  CVR_APPLY_HI: cover property (applied_code > `BVC_CODE_KNEE);

endmodule

// file: shared/bvc_cfg.svh
// Constants for the second buck converter voltage control register
`ifndef BVC_CFG_SVH
`define BVC_CFG_SVH

// ****************************************
// Register placement and field layout
// ****************************************
`define BVC_REG_ADDR      8'h17
`define BVC_PSE_BIT       3'h7
`define BVC_RSVD_BIT      3'h6
`define BVC_CODE_MSB      3'h5
`define BVC_ADDR_W        8
`define BVC_DATA_W        8
`define BVC_CODE_W        6
`define BVC_MV_W          11

// ****************************************
// Reset values
// ****************************************
`define BVC_PSE_RST       1'h1
`define BVC_CODE_RST      6'h32
`define BVC_RDATA_RST     8'h00
`define BVC_RSVD_VAL      1'h0

// ****************************************
// Voltage table, in millivolts
// ****************************************
`define BVC_CODE_KNEE     6'h32
`define BVC_MV_BASE       11'h352
`define BVC_MV_KNEE       11'h546
`define BVC_MV_STEP_LO    11'h00a
`define BVC_MV_STEP_HI    11'h019
`define BVC_MV_PAD        5'h00

// ****************************************
// Timing
// ****************************************
`define BVC_CLK_MHZ       20
`define BVC_BLANK_TIME_US 5000
`define BVC_BLANK_CYCLES  (`BVC_BLANK_TIME_US * `BVC_CLK_MHZ)

`endif

// file: shared/bvc_pkg.sv
// Types shared by the voltage control register design
package bvc_pkg;

  // ****************************************
  // Converter operating mode
  // ****************************************
  typedef enum logic {
    BVC_MODE_PWM,
    BVC_MODE_SKIP
  } bvc_mode_t;

  // Output voltage code
  typedef logic [5:0] bvc_code_t;

endpackage

// file: logic/bvc_blank_timer.sv
// Retriggerable countdown that holds a busy level after each start
`timescale 1ns/1ps
`include "bvc_cfg.svh"

module bvc_blank_timer
  import bvc_pkg::*;
#(
  parameter int CYCLES = `BVC_BLANK_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Control
  input  wire logic start,
  // Status
  output logic      busy
);

  localparam int CW = $clog2(CYCLES + 1);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (CYCLES < 1) begin : g_bad_cycles
    $error("bvc_blank_timer: CYCLES must be at least one");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          busy_reg;
  logic          busy_next;

  // Reload on start, else count down to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (start) begin
      cnt_next = CW'(CYCLES);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - CW'(1);
    end
    busy_next = (cnt_next != '0);
  end

  // Counter registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg  <= '0;
      busy_reg <= 1'h0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign busy = busy_reg;

endmodule

// file: verification/buck2_voltage_control_reg_bench.sv
// Self-checking bench for the second buck voltage control register
`timescale 1ns/1ps
`include "bvc_cfg.svh"

module buck2_voltage_control_reg_bench;
  import bvc_pkg::*;

  // ****************************************
  // Settings and bench state
  // ****************************************
  localparam int BLANK = 20;
  localparam int LIMIT = 20000;

  typedef struct {
    int          due;
    int          sel;
    logic [10:0] val;
  } bvc_note_t;

  logic                   clk;
  logic                   reset_n;
  logic [`BVC_ADDR_W-1:0] reg_addr;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [`BVC_DATA_W-1:0] reg_wdata;
  logic [`BVC_DATA_W-1:0] reg_rdata;
  logic                   password_ok;
  logic                   voltage_apply;
  logic                   voltage_apply_on_disable;
  logic                   light_load;
  logic                   pulse_skip_active;
  logic                   force_pwm;
  logic [`BVC_CODE_W-1:0] applied_code;
  logic [`BVC_MV_W-1:0]   vout_mv;
  logic                   monitor_blank;
  int                     cyc = 0;
  int                     miscompares = 0;
  int                     cmp_count = 0;
  bvc_note_t              notes[$];
  bvc_note_t              n;
  bvc_code_t              code;
  logic [7:0]             d;
  bvc_code_t              edge_codes[6] = '{6'h00, 6'h01, 6'h31,
                                            6'h32, 6'h33, 6'h3f};

  // Design under test with a short blanking count
  bvc_top #(.BLANK_CYCLES(BLANK)) bvc_top_i (
    .clk                      (clk),
    .reset_n                  (reset_n),
    .reg_addr                 (reg_addr),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_wdata                (reg_wdata),
    .reg_rdata                (reg_rdata),
    .password_ok              (password_ok),
    .voltage_apply            (voltage_apply),
    .voltage_apply_on_disable (voltage_apply_on_disable),
    .light_load               (light_load),
    .pulse_skip_active        (pulse_skip_active),
    .force_pwm                (force_pwm),
    .applied_code             (applied_code),
    .vout_mv                  (vout_mv),
    .monitor_blank            (monitor_blank)
  );

  // ****************************************
  // Clock, cycle count and hang limit
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string name, input logic [10:0] seen,
                       input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Millivolts expected for a code
  function automatic logic [10:0] mv(input bvc_code_t c);
    if (c <= `BVC_CODE_KNEE)
      return `BVC_MV_BASE + `BVC_MV_STEP_LO * c;
    return `BVC_MV_KNEE + `BVC_MV_STEP_HI * (c - `BVC_CODE_KNEE);
  endfunction

  task automatic note(input int lat, input int sel, input logic [10:0] v);
    notes.push_back('{cyc + lat, sel, v});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dat,
                    input logic pw);
    reg_addr = a;
    reg_wdata = dat;
    password_ok = pw;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    password_ok = 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    note(1, 0, {3'h0, exp});
    @(negedge clk);
    reg_rd = 1'b0;
  endtask

  task automatic apply(input logic alt, input bvc_code_t c);
    voltage_apply = ~alt;
    voltage_apply_on_disable = alt;
    note(1, 1, {5'h00, c});
    note(2, 2, mv(c));
    @(negedge clk);
    voltage_apply = 1'b0;
    voltage_apply_on_disable = 1'b0;
  endtask

  // ****************************************
  // Monitor: settle each due note in order
  // ****************************************
  always @(negedge clk) begin
    for (int i = 0; i < notes.size(); ) begin
      if (notes[i].due == cyc) begin
        n = notes[i];
        notes.delete(i);
        case (n.sel)
          0: check("reg_rdata", {3'h0, reg_rdata}, n.val);
          1: check("applied_code", {5'h00, applied_code}, n.val);
          2: check("vout_mv", vout_mv, n.val);
          3: check("monitor_blank", {10'h0, monitor_blank}, n.val);
          4: check("pulse_skip", {10'h0, pulse_skip_active}, n.val);
          default: check("force_pwm", {10'h000, force_pwm}, n.val);
        endcase
      end else begin
        i++;
      end
    end
  end

  // ****************************************
  // Stimulus, driven on the falling edge
  // ****************************************
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    password_ok = 1'b1;
    voltage_apply = 1'b0;
    voltage_apply_on_disable = 1'b0;
    light_load = 1'b0;
    void'($urandom(32'hde3037ea));
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    // Reset state, then refused writes leave it alone
    note(1, 1, 11'h032);
    note(1, 2, 11'h546);
    note(1, 5, 11'h000);
    rd(8'h17, 8'hb2);
    wr(8'h17, 8'h05, 1'b0);
    rd(8'h17, 8'hb2);
    wr(8'h16, 8'h05, 1'b1);
    rd(8'h17, 8'hb2);
    // Idle cycle so the read strobe is not lowered and raised at once
    @(negedge clk);
    rd(8'h16, 8'h00);
    // Reserved bit write, blanking window, staged code
    note(1, 3, 11'h001);
    note(BLANK, 3, 11'h001);
    note(BLANK + 1, 3, 11'h000);
    note(2, 5, 11'h001);
    note(2, 1, 11'h032);
    wr(8'h17, 8'h7f, 1'b1);
    rd(8'h17, 8'h3f);
    repeat (BLANK + 2) @(negedge clk);
    apply(1'b0, 6'h3f);
    // Rewrite during blanking restarts the count
    wr(8'h17, 8'h80, 1'b1);
    repeat (5) @(negedge clk);
    note(BLANK, 3, 11'h001);
    note(BLANK + 1, 3, 11'h000);
    wr(8'h17, 8'h80, 1'b1);
    // Let the restarted window run out before the next write
    repeat (BLANK + 1) @(negedge clk);
    // Light load enters pulse-skip after the sync delay
    light_load = 1'b1;
    note(2, 4, 11'h000);
    note(3, 4, 11'h001);
    repeat (4) @(negedge clk);
    note(2, 4, 11'h000);
    note(2, 5, 11'h001);
    wr(8'h17, 8'h00, 1'b1);
    repeat (3) @(negedge clk);
    note(2, 4, 11'h001);
    wr(8'h17, 8'h80, 1'b1);
    repeat (3) @(negedge clk);
    light_load = 1'b0;
    note(3, 4, 11'h000);
    repeat (4) @(negedge clk);
    // Table edges then random codes, both apply inputs
    for (int i = 0; i < 16; i++) begin
      code = (i < 6) ? edge_codes[i] : 6'($urandom);
      d = {1'b1, 1'($urandom), code};
      light_load = 1'($urandom);
      wr(8'h17, d, 1'b1);
      rd(8'h17, {2'b10, code});
      apply(i[0], code);
    end
    repeat (BLANK + 4) @(negedge clk);
    tally_and_finish();
  end
endmodule
